// *** design/cas_regs.sv ***
`timescale 1ns/1ps
`default_nettype none

// Function
// - writable 16-bit address assigned during identification
// - addressed commands act only on matching address, except a non-matching select deselects and a driver stage write ignores the address
// - address resets to 0x0001
// - select with 0x0000 sends all to standby
// - optional writable 16-bit driver stage register
// - card data reports driver stage presence
// - driver stage resets to 0x404
// - status shows state and completion codes
// - status poll returns the status register

// ============================================================
// card address, driver stage and status registers
// ============================================================
module cas_regs
	import cas_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// decoded command from the command parser
	input wire logic cmd_valid_i,
	input wire cas_cmd_t cmd_i,
	// response to the command serializer
	output logic resp_valid_o,
	output cas_resp_t resp_o,
	// register contents
	output logic [15:0] relative_address_o,
	output logic [15:0] driver_stage_o,
	output logic card_specific_data_drv_o,
	output logic [31:0] status_o,
	output cas_state_t card_state_o,
	output logic selected_o
);

	// ============================================================
	// declarations
	// ============================================================
	logic addr_match;
	logic illegal;
	logic wr_addr;
	logic wr_drv;
	logic answer;
	logic go_idle;
	logic illegal_r;
	logic illegal_nxt;
	logic [31:0] status_nxt;
	cas_state_t state;

	assign go_idle = cmd_valid_i && (cmd_i.index == CAS_CMD_GO_IDLE);

	assign addr_match = (cas_arg_addr(cmd_i.arg) == relative_address_o);

	// ============================================================
	// protocol state
	// ============================================================
	cas_state_fsm u_fsm (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.cmd_valid_i(cmd_valid_i),
		.cmd_i(cmd_i),
		.addr_match_i(addr_match),
		.state_o(state),
		.illegal_o(illegal),
		.wr_addr_o(wr_addr),
		.wr_drv_o(wr_drv),
		.answer_o(answer)
	);

	// ============================================================
	// relative address
	// ============================================================
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			relative_address_o <= CAS_ADDR_RST;
		end else if (go_idle) begin
			relative_address_o <= CAS_ADDR_RST;
		end else if (wr_addr) begin
			relative_address_o <= cas_arg_addr(cmd_i.arg);
		end
	end

	// ============================================================
	// driver stage
	// ============================================================
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			driver_stage_o <= CAS_DRV_RST;
		end else if (go_idle) begin
			driver_stage_o <= CAS_DRV_RST;
		end else if (wr_drv) begin
			driver_stage_o <= cas_arg_addr(cmd_i.arg);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			card_specific_data_drv_o <= 1'b0;
		end else begin
			card_specific_data_drv_o <= CAS_DRV_IMPL;
		end
	end

	// ============================================================
	// completion code
	// ============================================================
	// a new error wins over the clear made by the status answer
	always_comb begin
		illegal_nxt = illegal_r;
		if (answer && cmd_i.index == CAS_CMD_STATUS) illegal_nxt = 1'b0;
		if (go_idle) illegal_nxt = 1'b0;
		if (illegal) illegal_nxt = 1'b1;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			illegal_r <= 1'b0;
		end else begin
			illegal_r <= illegal_nxt;
		end
	end

	// ============================================================
	// status word
	// ============================================================
	// state and completion code
	always_comb begin
		status_nxt = '0;
		status_nxt[CAS_ST_STATE_LSB +: 4] = state;
		status_nxt[CAS_ST_ILLEGAL_BIT] = illegal_r;
		status_nxt[CAS_ST_READY_BIT] = (state == CAS_TRAN);
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			status_o <= '0;
			card_state_o <= CAS_IDLE;
			selected_o <= 1'b0;
		end else begin
			status_o <= status_nxt;
			card_state_o <= state;
			selected_o <= (state == CAS_TRAN);
		end
	end

	// ============================================================
	// responses
	// ============================================================
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			resp_valid_o <= 1'b0;
			resp_o <= '0;
		end else begin
			resp_valid_o <= answer;
			if (answer) begin
				resp_o.index <= cmd_i.index;
				if (cmd_i.index == CAS_CMD_SET_ADDR) begin
					resp_o.data <= {cas_arg_addr(cmd_i.arg), status_nxt[15:0]};
				end else begin
					resp_o.data <= status_nxt;
				end
			end
		end
	end

	// ============================================================
	// checks
	// ============================================================
	logic seen_r;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			seen_r <= 1'b0;
		end else begin
			seen_r <= 1'b1;
		end
	end

	sequence s_status_poll;
		cmd_valid_i && cmd_i.index == CAS_CMD_STATUS && addr_match
			&& (state == CAS_STBY || state == CAS_TRAN);
	endsequence

	sequence s_foreign_poll;
		cmd_valid_i && cmd_i.index == CAS_CMD_STATUS && !addr_match;
	endsequence

	a_addr_default: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		!seen_r |-> relative_address_o == 16'h0001)
		else $error("address not at default after reset");

	a_addr_assign: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(cmd_valid_i && cmd_i.index == CAS_CMD_SET_ADDR && state == CAS_IDENT
			&& cas_arg_addr(cmd_i.arg) != 16'h0000)
			|=> relative_address_o == $past(cas_arg_addr(cmd_i.arg))
				&& state == CAS_STBY)
		else $error("assigned address not stored");

	a_drv_default: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		!seen_r |-> driver_stage_o == 16'h0404)
		else $error("driver stage not at default after reset");

	a_drv_write: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(cmd_valid_i && cmd_i.index == CAS_CMD_SET_DRV && state == CAS_STBY)
			|=> driver_stage_o == $past(cmd_i.arg[31:16]))
		else $error("driver stage write lost");

	a_drv_flag: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		seen_r |-> card_specific_data_drv_o == CAS_DRV_IMPL)
		else $error("driver stage presence flag wrong");

	a_status_state: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		##1 status_o[12:9] == $past(state) && status_o[22] == $past(illegal_r))
		else $error("status word does not follow state");

	a_status_poll: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		s_status_poll |=> resp_valid_o && resp_o.index == 6'h0D
			&& resp_o.data[12:9] == $past(state))
		else $error("status poll not answered");

	a_foreign_silent: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		s_foreign_poll |=> !resp_valid_o)
		else $error("answered a poll for another address");

	a_error_sticky: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		illegal |=> illegal_r ##1 (illegal_r || $past(answer) || $past(go_idle)))
		else $error("completion code lost");

endmodule : cas_regs

`default_nettype wire

// *** design/cas_state_fsm.sv ***
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// card protocol state tracker
// ============================================================
module cas_state_fsm
	import cas_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// decoded command
	input wire logic cmd_valid_i,
	input wire cas_cmd_t cmd_i,
	input wire logic addr_match_i,
	// state and decisions
	output var cas_state_t state_o,
	output logic illegal_o,
	output logic wr_addr_o,
	output logic wr_drv_o,
	output logic answer_o
);

	cas_state_t state_nxt;
	logic bcast;

	assign bcast = (cas_arg_addr(cmd_i.arg) == CAS_ADDR_BCAST);

	always_comb begin
		state_nxt = state_o;
		illegal_o = 1'b0;
		wr_addr_o = 1'b0;
		wr_drv_o = 1'b0;
		answer_o = 1'b0;
		if (cmd_valid_i) begin
			case (cmd_i.index)
				CAS_CMD_GO_IDLE: begin
					state_nxt = CAS_IDLE;
				end
				CAS_CMD_IDENT: begin
					if (state_o == CAS_IDLE) state_nxt = CAS_IDENT;
					else illegal_o = 1'b1;
				end
				CAS_CMD_SET_ADDR: begin
					if (state_o != CAS_IDENT || bcast) begin
						illegal_o = 1'b1;
					end else begin
						wr_addr_o = 1'b1;
						answer_o = 1'b1;
						state_nxt = CAS_STBY;
					end
				end
				CAS_CMD_SET_DRV: begin
					if (state_o == CAS_STBY && CAS_DRV_IMPL) wr_drv_o = 1'b1;
					else illegal_o = 1'b1;
				end
				CAS_CMD_SELECT: begin
					if (bcast && (state_o == CAS_STBY || state_o == CAS_TRAN)) begin
						state_nxt = CAS_STBY;
					end else if (state_o == CAS_STBY && addr_match_i) begin
						state_nxt = CAS_TRAN;
						answer_o = 1'b1;
					end else if (state_o == CAS_TRAN && !addr_match_i) begin
						state_nxt = CAS_STBY;
					end else if (state_o == CAS_IDLE || state_o == CAS_IDENT) begin
						illegal_o = 1'b1;
					end
				end
				CAS_CMD_STATUS: begin
					if ((state_o == CAS_STBY || state_o == CAS_TRAN) && addr_match_i) begin
						answer_o = 1'b1;
					end
				end
				default: begin
					state_nxt = state_o;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_o <= CAS_IDLE;
		end else begin
			state_o <= state_nxt;
		end
	end

	// ============================================================
	// checks
	// ============================================================
	sequence s_bcast_select;
		cmd_valid_i && cmd_i.index == CAS_CMD_SELECT && bcast
			&& (state_o == CAS_STBY || state_o == CAS_TRAN);
	endsequence

	a_bcast_to_stby: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		s_bcast_select |=> (state_o == CAS_STBY))
		else $error("broadcast select did not return to standby");

	a_select_needs_match: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(state_o == CAS_STBY && !(cmd_valid_i && cmd_i.index == CAS_CMD_SELECT
			&& addr_match_i && !bcast)) |=> (state_o != CAS_TRAN))
		else $error("entered transfer without matching select");

endmodule : cas_state_fsm

`default_nettype wire

// *** pkg/cas_pkg.sv ***
// ============================================================
// card address and status register constants
// ============================================================
`default_nettype none

package cas_pkg;

	localparam int unsigned CAS_ADDR_W = 16;
	localparam int unsigned CAS_STAT_W = 32;

	// ============================================================
	// reset values, broadcast address and driver stage presence
	// ============================================================
	localparam logic [15:0] CAS_ADDR_RST = 16'h0001;
	localparam logic [15:0] CAS_ADDR_BCAST = 16'h0000;
	localparam logic [15:0] CAS_DRV_RST = 16'h0404;
	localparam logic CAS_DRV_IMPL = 1'b1;

	// ============================================================
	// command indices
	// ============================================================
	localparam logic [5:0] CAS_CMD_GO_IDLE = 6'h00;
	localparam logic [5:0] CAS_CMD_IDENT = 6'h02;
	localparam logic [5:0] CAS_CMD_SET_ADDR = 6'h03;
	localparam logic [5:0] CAS_CMD_SET_DRV = 6'h04;
	localparam logic [5:0] CAS_CMD_SELECT = 6'h07;
	localparam logic [5:0] CAS_CMD_STATUS = 6'h0D;

	// ============================================================
	// field positions
	// ============================================================
	localparam int unsigned CAS_ARG_ADDR_LSB = 16;
	localparam int unsigned CAS_ST_READY_BIT = 8;
	localparam int unsigned CAS_ST_STATE_LSB = 9;
	localparam int unsigned CAS_ST_ILLEGAL_BIT = 22;

	typedef enum logic [3:0] {
		CAS_IDLE,
		CAS_IDENT,
		CAS_STBY,
		CAS_TRAN
	} cas_state_t;

	typedef struct packed {
		logic [5:0] index;
		logic [31:0] arg;
	} cas_cmd_t;

	typedef struct packed {
		logic [5:0] index;
		logic [31:0] data;
	} cas_resp_t;

	// address field of a command argument
	function automatic logic [15:0] cas_arg_addr(input logic [31:0] arg);
		cas_arg_addr = arg[CAS_ARG_ADDR_LSB +: CAS_ADDR_W];
	endfunction : cas_arg_addr

endpackage : cas_pkg

`default_nettype wire

// *** tb/card_address_status_regs_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module card_address_status_regs_tb_top
	import cas_pkg::*;
;
	logic clk_i = 1'h0;
	logic rst_n_i = 1'h0;
	logic cmd_valid;
	cas_cmd_t cmd_bus;
	logic resp_valid;
	cas_resp_t resp;
	logic [15:0] addr;
	logic [15:0] drv;
	logic drv_flag;
	logic sel;
	logic [31:0] stat;
	cas_state_t cst;
	int failures = 0;
	int checked = 0;
	integer seed = 10528;
	logic [31:0] r;
	logic [15:0] a;
	cas_state_t e_st;
	logic [15:0] e_addr;
	logic [15:0] e_drv;
	logic e_ill;
	logic e_rv;
	logic [31:0] e_dat;
	logic [5:0] e_idx;

	initial begin
		forever #10 clk_i = ~clk_i;
	end

	cas_host_model i_host (.clk_i(clk_i), .cmd_valid_o(cmd_valid), .cmd_o(cmd_bus));

	cas_regs i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid),
		.cmd_i(cmd_bus), .resp_valid_o(resp_valid), .resp_o(resp),
		.relative_address_o(addr), .driver_stage_o(drv),
		.card_specific_data_drv_o(drv_flag), .status_o(stat), .card_state_o(cst),
		.selected_o(sel));

	// ============================================================
	// reporting
	// ============================================================
	task automatic report_and_stop();
		$display("errors %0d of %0d checks", failures, checked);
		if (failures == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic ok, input string m);
		checked++;
		if (ok !== 1'h1) begin
			failures++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask : chk

	// ============================================================
	// expected behaviour
	// ============================================================
	function automatic logic [31:0] st(input cas_state_t s, input logic ill);
		st = 32'h0000_0000;
		st[CAS_ST_ILLEGAL_BIT] = ill;
		st[CAS_ST_STATE_LSB +: 4] = s;
		st[CAS_ST_READY_BIT] = (s == CAS_TRAN);
	endfunction : st

	task automatic ref_rst();
		e_st = CAS_IDLE;
		e_addr = CAS_ADDR_RST;
		e_drv = CAS_DRV_RST;
		e_ill = 1'h0;
		e_rv = 1'h0;
	endtask : ref_rst

	task automatic ref_cmd(input logic [5:0] idx, input logic [31:0] arg);
		logic m;
		m = (arg[31:16] == e_addr);
		e_dat = st(e_st, e_ill);
		e_rv = 1'h0;
		e_idx = idx;
		case (idx)
			CAS_CMD_GO_IDLE: ref_rst();
			CAS_CMD_IDENT: if (e_st == CAS_IDLE) e_st = CAS_IDENT;
				else e_ill = 1'h1;
			CAS_CMD_SET_ADDR: if (e_st == CAS_IDENT && arg[31:16] != 16'h0000) begin
				e_rv = 1'h1;
				e_dat = {arg[31:16], e_dat[15:0]};
				e_addr = arg[31:16];
				e_st = CAS_STBY;
			end else e_ill = 1'h1;
			CAS_CMD_SET_DRV: if (e_st == CAS_STBY) e_drv = arg[31:16];
				else e_ill = 1'h1;
			CAS_CMD_SELECT: if (e_st == CAS_IDLE || e_st == CAS_IDENT) e_ill = 1'h1;
				else if (arg[31:16] == 16'h0000 || !m) e_st = CAS_STBY;
				else if (e_st == CAS_STBY) begin
					e_rv = 1'h1;
					e_st = CAS_TRAN;
				end
			CAS_CMD_STATUS: if (m && (e_st == CAS_STBY || e_st == CAS_TRAN)) begin
				e_rv = 1'h1;
				e_ill = 1'h0;
			end
			default: ;
		endcase
	endtask : ref_cmd

	// ============================================================
	// stimulus
	// ============================================================
	task automatic chk_resp();
		chk(resp_valid === e_rv, "answer strobe");
		if (e_rv === 1'h1) chk(resp.data === e_dat, "answer data");
		if (e_rv === 1'h1) chk(resp.index === e_idx, "answer index");
	endtask : chk_resp

	task automatic cmd(input logic [5:0] idx, input logic [31:0] arg);
		i_host.drive(idx, arg);
		chk_resp();
		ref_cmd(idx, arg);
	endtask : cmd

	task automatic idle();
		i_host.release_bus();
		chk_resp();
		e_rv = 1'h0;
	endtask : idle

	task automatic regs();
		repeat (3) idle();
		chk(addr === e_addr, "address");
		chk(drv === e_drv, "driver stage");
		chk(stat === st(e_st, e_ill), "status word");
		chk(cst === e_st, "card state");
		chk(sel === (e_st == CAS_TRAN), "selected");
		chk(drv_flag === CAS_DRV_IMPL, "driver stage flag");
	endtask : regs

	task automatic do_reset();
		@(negedge clk_i);
		rst_n_i = 1'h0;
		e_rv = 1'h0;
		repeat (16) @(negedge clk_i);
		chk(addr === CAS_ADDR_RST, "reset address");
		chk(drv === CAS_DRV_RST, "reset driver stage");
		chk(stat === 32'h0000_0000 && resp_valid === 1'h0, "reset status");
		rst_n_i = 1'h1;
		ref_rst();
	endtask : do_reset

	initial begin
		repeat (50000) @(posedge clk_i);
		chk(1'h0, "run timed out");
		report_and_stop();
	end

	initial begin
		do_reset();
		regs();
		cmd(CAS_CMD_SELECT, 32'h0001_0000);
		regs();
		cmd(CAS_CMD_GO_IDLE, 32'h0000_0000);
		cmd(CAS_CMD_IDENT, 32'h0000_0000);
		cmd(CAS_CMD_SET_ADDR, 32'h0000_0000);
		r = $random(seed);
		a = {1'h0, r[14:1], 1'h1};
		cmd(CAS_CMD_SET_ADDR, {a, r[31:16]});
		cmd(CAS_CMD_STATUS, {a, 16'h0000});
		cmd(CAS_CMD_STATUS, {~a, 16'h0000});
		regs();
		cmd(CAS_CMD_SET_DRV, {r[31:16], 16'h0000});
		cmd(CAS_CMD_SELECT, {a, 16'h0000});
		cmd(CAS_CMD_SET_DRV, {~r[31:16], 16'h0000});
		cmd(CAS_CMD_IDENT, 32'h0000_0000);
		cmd(CAS_CMD_SELECT, 32'h0000_0000);
		cmd(CAS_CMD_SELECT, {a, 16'h0000});
		cmd(CAS_CMD_SELECT, {~a, 16'h0000});
		regs();
		for (int i = 0; i < 300; i++) begin
			r = $random(seed);
			case (r[2:0])
				3'h0: cmd(CAS_CMD_STATUS, {e_addr, r[31:16]});
				3'h1: cmd(CAS_CMD_STATUS, {~e_addr, r[31:16]});
				3'h2: cmd(e_st == CAS_STBY ? CAS_CMD_SET_DRV : CAS_CMD_STATUS, r);
				3'h3: cmd(CAS_CMD_SELECT, {e_st == CAS_STBY ? e_addr : ~e_addr, r[15:0]});
				3'h4: cmd(CAS_CMD_SELECT, {16'h0000, r[15:0]});
				default: idle();
			endcase
			if (r[31:28] == 4'h0) regs();
		end
		regs();
		do_reset();
		regs();
		report_and_stop();
	end
endmodule : card_address_status_regs_tb_top

`default_nettype wire

// *** tb/cas_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// host controller model driving the command port
// ============================================================
module cas_host_model
	import cas_pkg::*;
(
	// clock
	input wire logic clk_i,
	// command port
	output logic cmd_valid_o,
	output cas_cmd_t cmd_o
);
	initial begin
		cmd_valid_o = 1'h0;
		cmd_o = '0;
	end

	// drive one command of any index
	// address travels in arg[31:16]; status may be polled at any time
	task automatic drive(input logic [5:0] idx, input logic [31:0] arg);
		@(negedge clk_i);
		cmd_valid_o = 1'h1;
		cmd_o.index = idx;
		cmd_o.arg = arg;
	endtask : drive

	// released port shows the inverse of the previous port contents
	task automatic release_bus();
		@(negedge clk_i);
		cmd_valid_o = 1'h0;
		cmd_o = ~cmd_o;
	endtask : release_bus
endmodule : cas_host_model

`default_nettype wire
